// >>> rtl/dcsm_ctrl.sv
/*
  Display cache SDRAM mode control: control-high register, graphics
  controller index, and command override of SDRAM access cycles.
  Assumes a one-cycle register strobe port with a memory/I-O space select,
  and an upstream access request that is already decoded to local memory.
*/
//
// Function
// - Refresh field 4:3, 00 off, 01 normal
// - No periodic refresh cycles while refresh disabled
// - Override field 2:0, 000 normal default
// - Override 001 turns accesses into NOP
// - Override 010 turns accesses into precharge-all
// - Override 011 issues MRS on address lines
// - Address bits 11:7 zero during MRS
// - Override 100 turns accesses into refresh
// - Diagnostic registers in I/O and memory
// - Index bits 3:0 select data-port register
// - Index bits 7:4 read as zero
// - Control register memory-mapped only
`timescale 1ns/1ns
module dcsm_ctrl #(
  parameter int REFRESH_PERIOD = dcsm_pkg::REFRESH_PERIOD_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                reg_sel,
  input  wire logic                reg_wr,
  input  wire logic                reg_mem_space,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_hit,
  output logic                     gr_data_sel,
  output logic      [3:0]          gr_index,
  input  wire logic [7:0]          gr_rdata,
  input  wire logic                acc_valid,
  input  wire logic                acc_write,
  input  wire logic [11:0]         acc_addr,
  output logic                     acc_ready,
  output dcsm_pkg::dcsm_cmd_t      sdram_cmd,
  output logic      [11:0]         local_mem_addr,
  output logic      [2:0]          command_override_field,
  output logic      [1:0]          refresh_rate_field
);

  logic [7:0]  ctrl_r;
  logic [3:0]  index_r;
  logic [15:0] ref_cnt_r;
  logic        ref_due_r;
  logic        hit_ctrl;
  logic        hit_index;
  logic        hit_data;
  logic        forced_nop_mode;
  logic        forced_precharge_all_mode;
  logic        forced_mode_set_mode;
  logic        forced_refresh_cycle_mode;
  logic        refresh_on;

  // Decode: control register only in memory space, diagnostic ones in both
  assign hit_ctrl  = reg_sel && reg_mem_space && (reg_addr == dcsm_pkg::OFF_LOCAL_MEM_CTRL_HIGH);
  assign hit_index = reg_sel && (reg_addr == dcsm_pkg::OFF_GRAPHICS_CTRL_INDEX);
  assign hit_data  = reg_sel && (reg_addr == dcsm_pkg::OFF_GRAPHICS_CTRL_DATA);
  assign reg_hit     = hit_ctrl || hit_index || hit_data;
  assign gr_data_sel = hit_data;
  assign gr_index    = index_r;

  assign refresh_rate_field     = ctrl_r[dcsm_pkg::REFRESH_MSB:dcsm_pkg::REFRESH_LSB];
  assign command_override_field = ctrl_r[dcsm_pkg::OVERRIDE_MSB:dcsm_pkg::OVERRIDE_LSB];
  assign forced_nop_mode           = command_override_field == dcsm_pkg::OVR_NOP;
  assign forced_precharge_all_mode = command_override_field == dcsm_pkg::OVR_PRECHARGE;
  assign forced_mode_set_mode      = command_override_field == dcsm_pkg::OVR_MODE_SET;
  assign forced_refresh_cycle_mode = command_override_field == dcsm_pkg::OVR_REFRESH_CYC;
  // Reserved refresh codes are treated as enabled, safer for memory contents
  assign refresh_on = refresh_rate_field != dcsm_pkg::REFRESH_OFF;

  // Control register; bits 7:5 reserved, held at zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= dcsm_pkg::CTRL_HIGH_RESET;
    end else if (hit_ctrl && reg_wr) begin
      ctrl_r <= {3'h0, reg_wdata[4:0]};
    end
  end

  // Index register; upper nibble never stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      index_r <= dcsm_pkg::INDEX_RESET;
    end else if (hit_index && reg_wr) begin
      index_r <= reg_wdata[dcsm_pkg::INDEX_MSB:0];
    end
  end

  // Read data, registered; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_sel && !reg_wr) begin
      if (hit_ctrl) begin
        reg_rdata <= ctrl_r;
      end else if (hit_index) begin
        reg_rdata <= {4'h0, index_r};
      end else if (hit_data) begin
        reg_rdata <= gr_rdata;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Refresh timer; it keeps running when off so a brief pause loses little
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_cnt_r <= 16'h0000;
      ref_due_r <= 1'b0;
    end else begin
      if (ref_cnt_r == 16'(REFRESH_PERIOD - 1)) begin
        ref_cnt_r <= 16'h0000;
      end else begin
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
      if (!refresh_on) begin
        ref_due_r <= 1'b0;
      end else if (ref_cnt_r == 16'(REFRESH_PERIOD - 1)) begin
        ref_due_r <= 1'b1;
      end else if (sdram_cmd == dcsm_pkg::DCSM_CMD_REF) begin
        ref_due_r <= 1'b0;
      end
    end
  end

  // Accesses stall only while a periodic refresh is being issued
  assign acc_ready = !(ref_due_r && refresh_on);

  // Command issue: override field forces the command of every access
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdram_cmd      <= dcsm_pkg::DCSM_CMD_NONE;
      local_mem_addr <= 12'h000;
    end else if (ref_due_r && refresh_on) begin
      sdram_cmd      <= dcsm_pkg::DCSM_CMD_REF;
      local_mem_addr <= 12'h000;
    end else if (acc_valid) begin
      local_mem_addr <= acc_addr;
      if (forced_nop_mode) begin
        sdram_cmd <= dcsm_pkg::DCSM_CMD_NOP;
      end else if (forced_precharge_all_mode) begin
        sdram_cmd <= dcsm_pkg::DCSM_CMD_PALL;
      end else if (forced_mode_set_mode) begin
        sdram_cmd      <= dcsm_pkg::DCSM_CMD_MRS;
        local_mem_addr <= {5'h00, acc_addr[6:0]};
      end else if (forced_refresh_cycle_mode) begin
        sdram_cmd <= dcsm_pkg::DCSM_CMD_CBR;
      end else if (command_override_field == dcsm_pkg::OVR_NORMAL) begin
        sdram_cmd <= acc_write ? dcsm_pkg::DCSM_CMD_WRITE : dcsm_pkg::DCSM_CMD_READ;
      end else begin
        sdram_cmd <= dcsm_pkg::DCSM_CMD_NONE; // Reserved codes issue nothing
      end
    end else begin
      sdram_cmd <= dcsm_pkg::DCSM_CMD_NONE;
    end
  end

  property p_ctrl_reset;
    @(posedge sys_clk) !rst_n |=> ctrl_r == dcsm_pkg::CTRL_HIGH_RESET && index_r == dcsm_pkg::INDEX_RESET;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("bad reset value");

  property p_no_refresh_off;
    @(posedge sys_clk) disable iff (!rst_n)
      refresh_rate_field == 2'h0 |=> sdram_cmd != dcsm_pkg::DCSM_CMD_REF;
  endproperty
  a_no_refresh_off: assert property (p_no_refresh_off) else $error("refresh while off");

  // A refused access cycle must be spent on a periodic refresh, never wasted
  property p_stall_refresh;
    @(posedge sys_clk) disable iff (!rst_n)
      !acc_ready |=> sdram_cmd == dcsm_pkg::DCSM_CMD_REF;
  endproperty
  a_stall_refresh: assert property (p_stall_refresh) else $error("stall without refresh");

  property p_nop;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_ready && command_override_field == 3'h1
      |=> sdram_cmd == dcsm_pkg::DCSM_CMD_NOP;
  endproperty
  a_nop: assert property (p_nop) else $error("nop not forced");

  property p_pall;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_ready && command_override_field == 3'h2
      |=> sdram_cmd == dcsm_pkg::DCSM_CMD_PALL;
  endproperty
  a_pall: assert property (p_pall) else $error("precharge not forced");

  property p_mrs;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_ready && command_override_field == 3'h3
      |=> sdram_cmd == dcsm_pkg::DCSM_CMD_MRS && local_mem_addr[6:0] == $past(acc_addr[6:0]);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode set wrong");

  property p_mrs_high_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      sdram_cmd == dcsm_pkg::DCSM_CMD_MRS |-> local_mem_addr[11:7] == 5'h00;
  endproperty
  a_mrs_high_zero: assert property (p_mrs_high_zero) else $error("mode high bits set");

  property p_cbr;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_ready && command_override_field == 3'h4
      |=> sdram_cmd == dcsm_pkg::DCSM_CMD_CBR;
  endproperty
  a_cbr: assert property (p_cbr) else $error("refresh cycle not forced");

  property p_normal;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_valid && acc_ready && command_override_field == 3'h0
      |=> sdram_cmd == ($past(acc_write) ? dcsm_pkg::DCSM_CMD_WRITE : dcsm_pkg::DCSM_CMD_READ);
  endproperty
  a_normal: assert property (p_normal) else $error("normal access wrong");

  property p_index_read;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_index && !reg_wr |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(index_r);
  endproperty
  a_index_read: assert property (p_index_read) else $error("index readback wrong");

  property p_ctrl_io_blocked;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_sel && reg_wr && !reg_mem_space |=> ctrl_r == $past(ctrl_r);
  endproperty
  a_ctrl_io_blocked: assert property (p_ctrl_io_blocked) else $error("control written via io");

  c_mrs: cover property (@(posedge sys_clk) sdram_cmd == dcsm_pkg::DCSM_CMD_MRS);
  c_refresh: cover property (@(posedge sys_clk) sdram_cmd == dcsm_pkg::DCSM_CMD_REF);
  c_nop_then_pall: cover property (@(posedge sys_clk)
    sdram_cmd == dcsm_pkg::DCSM_CMD_NOP ##[1:20] sdram_cmd == dcsm_pkg::DCSM_CMD_PALL);
  c_data_port: cover property (@(posedge sys_clk) hit_data && !reg_wr);

endmodule : dcsm_ctrl

// >>> rtl/dcsm_pkg.sv
/*
  Package for the display cache SDRAM mode control block: offsets, field
  positions, reset values and command codes.
  Assumes a byte-wide register access port shared by memory and I/O space.
*/
package dcsm_pkg;
  // Register offsets; memory offset of a diagnostic register equals its I/O address
  localparam logic [15:0] OFF_LOCAL_MEM_CTRL_HIGH  = 16'h3002;
  localparam logic [15:0] OFF_GRAPHICS_CTRL_INDEX  = 16'h03ce;
  localparam logic [15:0] OFF_GRAPHICS_CTRL_DATA   = 16'h03cf;
  // Field positions
  localparam int REFRESH_LSB   = 3;
  localparam int REFRESH_MSB   = 4;
  localparam int OVERRIDE_LSB  = 0;
  localparam int OVERRIDE_MSB  = 2;
  localparam int INDEX_MSB     = 3;
  // Reset values
  localparam logic [7:0] CTRL_HIGH_RESET = 8'h08;
  localparam logic [3:0] INDEX_RESET     = 4'h0;
  // Refresh rate codes
  localparam logic [1:0] REFRESH_OFF    = 2'h0;
  localparam logic [1:0] REFRESH_NORMAL = 2'h1;
  // Command override codes
  localparam logic [2:0] OVR_NORMAL      = 3'h0;
  localparam logic [2:0] OVR_NOP         = 3'h1;
  localparam logic [2:0] OVR_PRECHARGE   = 3'h2;
  localparam logic [2:0] OVR_MODE_SET    = 3'h3;
  localparam logic [2:0] OVR_REFRESH_CYC = 3'h4;
  // SDRAM command outputs
  typedef enum logic [2:0] {
    DCSM_CMD_NONE  = 3'h0,
    DCSM_CMD_NOP   = 3'h1,
    DCSM_CMD_PALL  = 3'h2,
    DCSM_CMD_MRS   = 3'h3,
    DCSM_CMD_CBR   = 3'h4,
    DCSM_CMD_READ  = 3'h5,
    DCSM_CMD_WRITE = 3'h6,
    DCSM_CMD_REF   = 3'h7
  } dcsm_cmd_t;
  // Refresh interval in cycles (plain default)
  localparam int REFRESH_PERIOD_CYC = 1560;
endpackage : dcsm_pkg

// >>> testbench/dcsm_sdram_model.sv
/*
  Far-side SDRAM model: counts periodic refreshes and flags bad mode sets.
  Assumes registered command and address lines from the mode control block.
*/
`timescale 1ns/1ns
module dcsm_sdram_model (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire dcsm_pkg::dcsm_cmd_t sdram_cmd,
  input  wire logic [11:0]         local_mem_addr,
  output logic      [7:0]          ref_cnt,
  output logic                     mrs_bad
);
  // Refresh count lets the bench see whether refresh really stops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) ref_cnt <= 8'h00;
    else if (sdram_cmd == dcsm_pkg::DCSM_CMD_REF) ref_cnt <= ref_cnt + 8'h01;
  end
  // Sticky, so a single bad mode set is never missed
  always_ff @(posedge sys_clk) begin
    if (!rst_n) mrs_bad <= 1'b0;
    else if (sdram_cmd == dcsm_pkg::DCSM_CMD_MRS && local_mem_addr[11:7] != 5'h00)
      mrs_bad <= 1'b1;
  end
endmodule : dcsm_sdram_model

// >>> testbench/tb.sv
/*
  Testbench for the SDRAM mode control block with an SDRAM model.
  Assumes a one-cycle register strobe and the access handshake of the block.
*/
`timescale 1ns/1ns
module tb;
  logic                sys_clk = 0, rst_n = 0, reg_sel = 0, reg_wr = 0, reg_mem_space = 0;
  logic                acc_valid = 0, acc_write = 0, reg_hit, gr_data_sel, acc_ready, mrs_bad;
  logic [15:0]         reg_addr = 16'h0000;
  logic [7:0]          reg_wdata = 8'h00, reg_rdata, gr_rdata, ref_cnt, rd, c0;
  logic [11:0]         acc_addr = 12'h000, local_mem_addr;
  logic [3:0]          gr_index;
  logic                hit, dsel;
  logic [2:0]          command_override_field;
  logic [1:0]          refresh_rate_field;
  dcsm_pkg::dcsm_cmd_t sdram_cmd;
  int                  errors = 0, tests_run = 0, st = 0;
  // Bench stands in for the external graphics registers
  assign gr_rdata = {4'h5, gr_index};
  dcsm_ctrl #(.REFRESH_PERIOD(16)) dcsm_ctrl_i (.sys_clk, .rst_n, .reg_sel, .reg_wr,
    .reg_mem_space, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .gr_data_sel, .gr_index,
    .gr_rdata, .acc_valid, .acc_write, .acc_addr, .acc_ready, .sdram_cmd, .local_mem_addr,
    .command_override_field, .refresh_rate_field);
  dcsm_sdram_model dcsm_sdram_model_i (.sys_clk, .rst_n, .sdram_cmd, .local_mem_addr,
    .ref_cnt, .mrs_bad);
  // Clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One register strobe; decode outputs are caught mid-cycle, read data a cycle late
  task rw(input logic m, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_sel, reg_wr, reg_mem_space, reg_addr, reg_wdata} <= {1'b1, w, m, a, d};
    @(negedge sys_clk);
    {hit, dsel} = {reg_hit, gr_data_sel};
    @(posedge sys_clk);
    reg_sel <= 1'b0;
    @(posedge sys_clk);
    #1 rd = reg_rdata;
  endtask : rw
  // Access held until taken; the command stands just after the taking edge
  task acc(input logic w, input logic [11:0] a);
    int i;
    i = 0;
    @(posedge sys_clk);
    {acc_valid, acc_write, acc_addr} <= {1'b1, w, a};
    @(negedge sys_clk);
    while (acc_ready !== 1'b1) begin
      if (++i > 40) begin
        errors++;
        stop_test;
      end
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    #1;
  endtask : acc
  // Idle window; refused cycles are counted mid-cycle where acc_ready is settled
  task idle64;
    st = 0;
    repeat (64) begin
      @(negedge sys_clk);
      if (acc_ready !== 1'b1) st++;
    end
    @(posedge sys_clk);
    #1;
  endtask : idle64
  task t_regs;
    rw(1, 0, 16'h3002, 8'h00);
    chk("ctrl reset", 12'h008, rd);
    chk("ctrl hit", 12'h001, {11'h000, hit});
    rw(0, 1, 16'h3002, 8'h00);
    rw(1, 0, 16'h3002, 8'h00);
    chk("ctrl io write", 12'h008, rd);
    rw(0, 0, 16'h3002, 8'h00);
    chk("ctrl io read", 12'h000, rd);
    chk("ctrl io hit", 12'h000, {11'h000, hit});
    rw(1, 0, 16'h1234, 8'h00);
    chk("unmapped", 12'h000, rd);
    chk("unmapped hit", 12'h000, {11'h000, hit});
    rw(0, 1, 16'h03ce, 8'hff);
    rw(0, 0, 16'h03ce, 8'h00);
    chk("index", 12'h00f, rd);
    chk("gr_index", 12'h00f, gr_index);
    rw(1, 1, 16'h03ce, 8'h05);
    rw(0, 0, 16'h03ce, 8'h00);
    chk("index mem", 12'h005, rd);
    chk("index hit", 12'h001, {11'h000, hit});
    rw(1, 0, 16'h03cf, 8'h00);
    chk("data port", 12'h055, rd);
    chk("data sel", 12'h001, {11'h000, dsel});
    chk("data hit", 12'h001, {11'h000, hit});
  endtask : t_regs
  // NOP first, then every forced mode, normal reads and writes, a reserved code
  task t_modes;
    logic [2:0] code [7] = '{1, 2, 3, 4, 0, 0, 5};
    logic       wr [7] = '{0, 0, 0, 0, 0, 1, 0};
    logic [2:0] cmd [7] = '{1, 2, 3, 4, 5, 6, 0};
    for (int k = 0; k < 7; k++) begin
      rw(1, 1, 16'h3002, {5'h00, code[k]});
      chk("override", code[k], command_override_field);
      acc(wr[k], 12'hfab);
      chk("cmd", cmd[k], sdram_cmd);
      if (k < 6) chk("addr", (code[k] == 3) ? 12'h02b : 12'hfab, local_mem_addr);
    end
    chk("mrs high bits", 12'h000, mrs_bad);
  endtask : t_modes
  task t_refresh;
    c0 = ref_cnt;
    idle64;
    chk("no refresh", c0, ref_cnt);
    chk("no stall", 12'h000, st[11:0]);
    rw(1, 1, 16'h3002, 8'h08);
    chk("refresh field", 12'h001, refresh_rate_field);
    idle64;
    chk("refresh runs", 12'h001, {11'h000, (ref_cnt - c0) > 8'h02});
    chk("stall seen", 12'h001, {11'h000, st > 0});
    acc(0, 12'h123);
    chk("read", 12'h005, sdram_cmd);
  endtask : t_refresh
  // Mid-run reset: reserved control bits stay zero, then all returns to defaults
  task t_reset;
    rw(1, 1, 16'h3002, 8'hff);
    rw(1, 0, 16'h3002, 8'h00);
    chk("ctrl reserved", 12'h01f, rd);
    rw(0, 1, 16'h03ce, 8'h09);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rw(1, 0, 16'h3002, 8'h00);
    chk("ctrl after reset", 12'h008, rd);
    chk("index after reset", 12'h000, gr_index);
    chk("cmd after reset", 12'h000, sdram_cmd);
  endtask : t_reset
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_modes;
    t_refresh;
    t_reset;
    stop_test;
  end
endmodule : tb
